// [rtl/ffp_defines.svh]
// constants of the flash fault status and protection block
// assumes byte-wide registers on a 16-bit address plain port
`ifndef FFP_DEFINES_SVH
`define FFP_DEFINES_SVH

// ************************************************************
// register addresses
// ************************************************************
`define FFP_ADDR_CONFIG    16'h3025
`define FFP_ADDR_CMD_STAT  16'h3026
`define FFP_ADDR_ERR_STAT  16'h3027
`define FFP_ADDR_PROT      16'h3028

// ************************************************************
// field positions and fixed values
// ************************************************************
`define FFP_ERR_SINGLE_BIT 0
`define FFP_ERR_DOUBLE_BIT 1
`define FFP_CFG_IGNORE_SINGLE_FAULT_BIT  0
`define FFP_STAT_VIOL_BIT  4
`define FFP_PROT_RSV_HIGH  1'h1
`define FFP_PROT_RSV_LOW   3'h0
`define FFP_PROT_RESET     8'h78
`define FFP_ZERO_BYTE      8'h00

// ************************************************************
// flash addresses and largest high size code
// ************************************************************
`define FFP_CFG_PROT_ADDR  16'hff7c
`define FFP_FLASH_END_P1   17'h10000
`define FFP_HS_MAX         2'h3

`endif

// [rtl/ffp_pkg.sv]
// types shared by the flash fault status and protection block
// assumes ffp_defines.svh for the numbers
package ffp_pkg;

  // protection register layout, msb first
  typedef struct packed {
    logic       polarity;
    logic       rsv_high;
    logic       high_disable;
    logic [1:0] high_size;
    logic [2:0] rsv_low;
  } ffp_prot_t;

  typedef enum logic [1:0] {
    FFP_CMD_PROGRAM,
    FFP_CMD_SECTOR_ERASE,
    FFP_CMD_BLOCK_ERASE
  } ffp_cmd_t;

  typedef enum logic [1:0] {
    FFP_ST_FETCH,
    FFP_ST_WAIT,
    FFP_ST_RUN
  } ffp_state_t;

endpackage

// [rtl/ffp_prot_if.sv]
// protection setting and address query between top and range checker
// assumes one clock domain; the query is purely combinational
`timescale 1ns/1ps
interface ffp_prot_if;
  import ffp_pkg::*;

  ffp_prot_t   setting;
  logic [15:0] addr;
  logic        hit;
  logic        any_hit;

  modport owner (output setting, output addr, input hit, input any_hit);
  modport judge (input setting, input addr, output hit, output any_hit);
endinterface

// [rtl/ffp_sticky_flag.sv]
// one sticky status flag, set by hardware, cleared by writing one
// assumes set and clear are one-cycle pulses on clk
`timescale 1ns/1ps
module ffp_sticky_flag (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  // set beats a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

endmodule

// [rtl/ffp_prot_check.sv]
// decides whether a flash address, or any of the block, is protected
// assumes the flash block spans flash_base up to the top address
`timescale 1ns/1ps
`include "ffp_defines.svh"
module ffp_prot_check
  import ffp_pkg::*;
#(
  parameter logic [15:0] FLASH_BASE = 16'hc000,
  parameter logic [15:0] HIGH_UNIT  = 16'h0800
) (
  ffp_prot_if.judge pif
);

  logic [16:0] span;
  logic [16:0] top_start;
  logic        in_flash;
  logic        in_top;
  logic        range_on;

  assign span      = {1'b0, HIGH_UNIT} << pif.setting.high_size;
  assign top_start = `FFP_FLASH_END_P1 - span;
  assign in_flash  = pif.addr >= FLASH_BASE;
  assign in_top    = {1'b0, pif.addr} >= top_start;
  assign range_on  = !pif.setting.high_disable;

  // polarity set: range is protected; clear: range is the only hole
  always_comb begin
    if (pif.setting.polarity) begin
      pif.hit     = in_flash && range_on && in_top;
      pif.any_hit = range_on;
    end else begin
      pif.hit     = in_flash && !(range_on && in_top);
      pif.any_hit = !range_on || (top_start > {1'b0, FLASH_BASE});
    end
  end

endmodule

// [rtl/ffp_fault_prot.sv]
// flash fault status flags and program/erase protection register
// assumes flash read path and command controller on the same clock
//
// Contract
// - reserved error and low protection bits read zero
// - double ecc fault sets double flag
// - read of busy block sets double flag
// - double flag cleared only by writing one
// - ecc fault gives single or double, never both
// - collision sets double, and single too while ignore bit clear
// - fault flags stored two cycles after read
// - single flag set only while ignore bit clear
// - single flag cleared only by writing one
// - protection writes may only grow protected area
// - protection loaded from configuration byte at reset
// - protected program or erase refused, violation set
// - block erase refused if any sector protected
// - polarity bit selects protect or unprotect meaning
// - protection bit 6 always reads one
// - high disable bit governs range ending at top
// - high size writable only while high disable set
// - violation cleared by writing one, blocks launch
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "ffp_defines.svh"
module ffp_fault_prot
  import ffp_pkg::*;
#(
  parameter logic [15:0] FLASH_BASE = 16'hc000,
  parameter logic [15:0] HIGH_UNIT  = 16'h0800
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // flash array read path
  input  wire logic        rd_valid,
  input  wire logic        rd_ecc_single,
  input  wire logic        rd_ecc_double,
  input  wire logic        rd_block_busy,
  // configuration byte fetch at reset
  output logic             cfg_rd_req,
  output logic      [15:0] cfg_rd_addr,
  input  wire logic        cfg_rd_valid,
  input  wire logic [7:0]  cfg_rd_data,
  output logic             cfg_done,
  // command controller
  input  wire logic        cmd_valid,
  input  wire ffp_cmd_t    cmd_kind,
  input  wire logic [15:0] cmd_addr,
  output logic             cmd_ready,
  output logic             cmd_go,
  output logic             cmd_refused,
  // status levels
  output logic             single_fault_flag,
  output logic             double_fault_flag,
  output logic             protection_violation_flag,
  output ffp_prot_t        protection_reg
);

  // ************************************************************
  // parameter checks
  // ************************************************************
  generate
    if (HIGH_UNIT == 16'h0000) begin : g_bad_unit
      $error("high range unit must be nonzero");
    end
    if ((`FFP_FLASH_END_P1 - {1'b0, FLASH_BASE}) < ({1'b0, HIGH_UNIT} << `FFP_HS_MAX))
    begin : g_bad_base
      $error("largest high range does not fit in flash");
    end
    // the protection byte must lie inside the guarded flash
    if (FLASH_BASE > `FFP_CFG_PROT_ADDR) begin : g_bad_cfg
      $error("protection byte lies below the flash block");
    end
  endgenerate

  // ************************************************************
  // declarations
  // ************************************************************
  ffp_state_t  state;
  ffp_state_t  next_state;
  logic        ignore_single_fault;
  logic        single_ev;
  logic        double_ev;
  logic        single_pipe;
  logic        double_pipe;
  logic        wr_err;
  logic        wr_prot;
  logic        wr_cfg;
  logic        wr_stat;
  logic        clr_single;
  logic        clr_double;
  logic        clr_viol;
  logic        running;
  logic        cmd_blocked;
  logic        cmd_prot_fail;
  logic        viol_set;
  ffp_prot_t   prot_cand;
  logic        prot_ok;
  ffp_prot_t   cfg_loaded;
  logic [7:0]  error_status_reg;
  logic [7:0]  flash_config_reg;
  logic [7:0]  command_status_reg;
  logic [7:0]  next_rdata;

  ffp_prot_if pif ();

  // ************************************************************
  // protection containment test
  // ************************************************************
  // true when every address protected under old stays protected
  function automatic logic prot_grows(input ffp_prot_t old_p, input ffp_prot_t new_p);
    logic old_none;
    logic old_all;
    logic new_all;
    old_none = old_p.polarity && old_p.high_disable;
    old_all  = !old_p.polarity && old_p.high_disable;
    new_all  = !new_p.polarity && new_p.high_disable;
    if (old_none) begin
      prot_grows = 1'b1;
    end else if (new_all) begin
      prot_grows = 1'b1;
    end else if (old_all) begin
      prot_grows = 1'b0;
    end else if (old_p.polarity) begin
      // protected top range may only widen
      prot_grows = new_p.polarity && !new_p.high_disable
                   && (new_p.high_size >= old_p.high_size);
    end else begin
      // unprotected hole at the top may only narrow
      prot_grows = !new_p.polarity && !new_p.high_disable
                   && (new_p.high_size <= old_p.high_size);
    end
  endfunction

  // ************************************************************
  // reset sequence fetch of the protection byte
  // ************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      FFP_ST_FETCH: begin
        next_state = FFP_ST_WAIT;
      end
      FFP_ST_WAIT: begin
        if (cfg_rd_valid) begin
          next_state = FFP_ST_RUN;
        end
      end
      FFP_ST_RUN: begin
        next_state = FFP_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= FFP_ST_FETCH;
    end else begin
      state <= next_state;
    end
  end

  // commands and protection writes wait for the loaded byte
  assign running     = (state == FFP_ST_RUN);
  assign cfg_done    = running;
  assign cfg_rd_req  = (state == FFP_ST_FETCH);
  assign cfg_rd_addr = `FFP_CFG_PROT_ADDR;

  // loaded byte with its fixed bits forced
  always_comb begin
    cfg_loaded          = ffp_prot_t'(cfg_rd_data);
    cfg_loaded.rsv_high = `FFP_PROT_RSV_HIGH;
    cfg_loaded.rsv_low  = `FFP_PROT_RSV_LOW;
  end

  // ************************************************************
  // register write decode
  // ************************************************************
  assign wr_err  = reg_wr && (reg_addr == `FFP_ADDR_ERR_STAT);
  assign wr_prot = reg_wr && (reg_addr == `FFP_ADDR_PROT);
  assign wr_cfg  = reg_wr && (reg_addr == `FFP_ADDR_CONFIG);
  assign wr_stat = reg_wr && (reg_addr == `FFP_ADDR_CMD_STAT);

  assign clr_single = wr_err && reg_wdata[`FFP_ERR_SINGLE_BIT];
  assign clr_double = wr_err && reg_wdata[`FFP_ERR_DOUBLE_BIT];
  assign clr_viol   = wr_stat && reg_wdata[`FFP_STAT_VIOL_BIT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ignore_single_fault <= 1'b0;
    end else if (wr_cfg) begin
      ignore_single_fault <= reg_wdata[`FFP_CFG_IGNORE_SINGLE_FAULT_BIT];
    end
  end

  // ************************************************************
  // fault capture from the read path
  // ************************************************************
  // double wins over single for a plain ecc fault
  // a collision under ignore leaves only the double flag
  assign double_ev = rd_valid && (rd_ecc_double || rd_block_busy);
  assign single_ev = rd_valid && !ignore_single_fault
                     && (rd_block_busy
                         || (rd_ecc_single && !rd_ecc_double));

  // one stage between the read and the stored flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      single_pipe <= 1'b0;
      double_pipe <= 1'b0;
    end else begin
      single_pipe <= single_ev;
      double_pipe <= double_ev;
    end
  end

  ffp_sticky_flag u_single (
    .clk    (clk),
    .resetn (resetn),
    .set    (single_pipe),
    .clr    (clr_single),
    .flag   (single_fault_flag)
  );

  ffp_sticky_flag u_double (
    .clk    (clk),
    .resetn (resetn),
    .set    (double_pipe),
    .clr    (clr_double),
    .flag   (double_fault_flag)
  );

  // ************************************************************
  // protection register
  // ************************************************************
  // size field follows the write only while the range is disabled
  always_comb begin
    prot_cand              = ffp_prot_t'(reg_wdata);
    prot_cand.rsv_high     = `FFP_PROT_RSV_HIGH;
    prot_cand.rsv_low      = `FFP_PROT_RSV_LOW;
    if (!protection_reg.high_disable) begin
      prot_cand.high_size = protection_reg.high_size;
    end
  end

  // writes before the fetch completes are dropped
  assign prot_ok = prot_grows(protection_reg, prot_cand);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      protection_reg <= ffp_prot_t'(`FFP_PROT_RESET);
    end else if ((state == FFP_ST_WAIT) && cfg_rd_valid) begin
      protection_reg <= cfg_loaded;
    end else if (running && wr_prot && prot_ok) begin
      protection_reg <= prot_cand;
    end
  end

  // ************************************************************
  // command gating against protection
  // ************************************************************
  assign pif.setting = protection_reg;
  assign pif.addr    = cmd_addr;

  ffp_prot_check #(
    .FLASH_BASE (FLASH_BASE),
    .HIGH_UNIT  (HIGH_UNIT)
  ) u_check (
    .pif (pif.judge)
  );

  // launch is held off while a violation is pending
  assign cmd_blocked   = !running || protection_violation_flag;
  assign cmd_ready     = !cmd_blocked;
  // an undefined kind is judged like a block erase, the safe side
  always_comb begin
    unique case (cmd_kind)
      FFP_CMD_PROGRAM:      cmd_prot_fail = pif.hit;
      FFP_CMD_SECTOR_ERASE: cmd_prot_fail = pif.hit;
      FFP_CMD_BLOCK_ERASE:  cmd_prot_fail = pif.any_hit;
      default:              cmd_prot_fail = pif.any_hit;
    endcase
  end

  assign viol_set      = cmd_valid && !cmd_blocked && cmd_prot_fail;
  assign cmd_go        = cmd_valid && !cmd_blocked && !cmd_prot_fail;
  assign cmd_refused   = cmd_valid && !cmd_go;

  ffp_sticky_flag u_viol (
    .clk    (clk),
    .resetn (resetn),
    .set    (viol_set),
    .clr    (clr_viol),
    .flag   (protection_violation_flag)
  );

  // ************************************************************
  // register read
  // ************************************************************
  always_comb begin
    error_status_reg                      = `FFP_ZERO_BYTE;
    error_status_reg[`FFP_ERR_SINGLE_BIT] = single_fault_flag;
    error_status_reg[`FFP_ERR_DOUBLE_BIT] = double_fault_flag;
  end

  always_comb begin
    flash_config_reg                     = `FFP_ZERO_BYTE;
    flash_config_reg[`FFP_CFG_IGNORE_SINGLE_FAULT_BIT] = ignore_single_fault;
  end

  always_comb begin
    command_status_reg                     = `FFP_ZERO_BYTE;
    command_status_reg[`FFP_STAT_VIOL_BIT] = protection_violation_flag;
  end

  always_comb begin
    unique case (reg_addr)
      `FFP_ADDR_ERR_STAT: next_rdata = error_status_reg;
      `FFP_ADDR_PROT:     next_rdata = protection_reg;
      `FFP_ADDR_CONFIG:   next_rdata = flash_config_reg;
      `FFP_ADDR_CMD_STAT: next_rdata = command_status_reg;
      default:            next_rdata = `FFP_ZERO_BYTE;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `FFP_ZERO_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `FFP_ZERO_BYTE;
    end
  end

endmodule

// [test/ffp_fault_prot_properties.sv]
// port assertions of the flash fault status and protection block
// assumes one clock domain, bound onto ffp_fault_prot
`timescale 1ns/1ps
module ffp_fault_prot_properties
  import ffp_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        rd_valid,
  input wire logic        rd_ecc_single,
  input wire logic        rd_ecc_double,
  input wire logic        rd_block_busy,
  input wire logic        cmd_ready,
  input wire logic        cmd_go,
  input wire logic        cmd_refused,
  input wire logic        single_fault_flag,
  input wire logic        double_fault_flag,
  input wire logic        protection_violation_flag,
  input wire ffp_prot_t   protection_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ************
  // port relations
  // ************
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_err_read: assert property ($past(reg_rd) && $past(reg_addr) == 16'h3027
    |-> reg_rdata == {6'h00, $past(double_fault_flag), $past(single_fault_flag)})
    else $error("error status read wrong");
  a_prot_read: assert property ($past(reg_rd) && $past(reg_addr) == 16'h3028
    |-> reg_rdata == $past(protection_reg))
    else $error("protection read wrong");
  a_prot_fixed: assert property (protection_reg.rsv_high && protection_reg.rsv_low == 3'h0)
    else $error("protection reserved bits wrong");
  a_double_set: assert property (rd_valid && (rd_ecc_double || rd_block_busy)
    |-> ##2 double_fault_flag)
    else $error("double flag not set");
  a_double_cause: assert property ($rose(double_fault_flag) |-> $past(rd_valid, 2)
    && ($past(rd_ecc_double, 2) || $past(rd_block_busy, 2)))
    else $error("double flag set without cause");
  a_single_cause: assert property ($rose(single_fault_flag) |-> $past(rd_valid, 2)
    && ($past(rd_block_busy, 2) || $past(rd_ecc_single, 2) && !$past(rd_ecc_double, 2)))
    else $error("single flag set without cause");
  a_double_clear: assert property ($fell(double_fault_flag) |-> $past(reg_wr)
    && $past(reg_addr) == 16'h3027 && $past(reg_wdata[1]))
    else $error("double flag cleared without write");
  a_single_clear: assert property ($fell(single_fault_flag) |-> $past(reg_wr)
    && $past(reg_addr) == 16'h3027 && $past(reg_wdata[0]))
    else $error("single flag cleared without write");
  a_viol_clear: assert property ($fell(protection_violation_flag) |-> $past(reg_wr)
    && $past(reg_addr) == 16'h3026 && $past(reg_wdata[4]))
    else $error("violation flag cleared without write");
  a_viol_block: assert property (protection_violation_flag |-> !cmd_go && !cmd_ready)
    else $error("command launched during violation");
  a_viol_set: assert property (cmd_refused && cmd_ready |=> protection_violation_flag)
    else $error("violation flag not set");
endmodule

bind ffp_fault_prot ffp_fault_prot_properties i_props (.clk, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rd_valid, .rd_ecc_single, .rd_ecc_double,
  .rd_block_busy, .cmd_ready, .cmd_go, .cmd_refused, .single_fault_flag,
  .double_fault_flag, .protection_violation_flag, .protection_reg);

// [test/ffp_flash_model.sv]
// flash side model answering the protection byte fetch
// assumes the fetch request is seen on the first edge after reset
`timescale 1ns/1ps
module ffp_flash_model #(
  parameter logic [7:0] PROT_BYTE = 8'ha7,
  parameter int         LAT       = 3
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        cfg_rd_req,
  input  wire logic [15:0] cfg_rd_addr,
  output logic             cfg_rd_valid,
  output logic      [7:0]  cfg_rd_data
);
  int cnt;

  // ************
  // delayed answer, data churns when not valid
  // ************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt          <= 0;
      cfg_rd_valid <= 1'b0;
      cfg_rd_data  <= ~PROT_BYTE;
    end else begin
      cfg_rd_valid <= (cnt == 1);
      cfg_rd_data  <= (cnt == 1 && cfg_rd_addr == 16'hff7c) ? PROT_BYTE : ~cfg_rd_data;
      if (cfg_rd_req) begin
        cnt <= LAT;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// [test/tb.sv]
// self-checking bench of the flash fault status and protection block
// assumes the flash model answers the protection byte fetch
`timescale 1ns/1ps
module tb import ffp_pkg::*;;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        rd_valid = 1'b0;
  logic        rd_ecc_single = 1'b0;
  logic        rd_ecc_double = 1'b0;
  logic        rd_block_busy = 1'b0;
  logic        cfg_rd_req, cfg_rd_valid, cfg_done;
  logic [15:0] cfg_rd_addr;
  logic [7:0]  cfg_rd_data;
  logic        cmd_valid = 1'b0;
  ffp_cmd_t    cmd_kind = FFP_CMD_PROGRAM;
  logic [15:0] cmd_addr = 16'h0000;
  logic        cmd_ready, cmd_go, cmd_refused;
  logic        single_fault_flag, double_fault_flag, protection_violation_flag;
  ffp_prot_t   protection_reg;
  int          fail_count = 0;
  int          comparisons = 0;
  logic [4:0]  ft [6] = '{5'h0c, 5'h12, 5'h16, 5'h19, 5'h04, 5'h11};

  always #5 clk = ~clk;

  ffp_fault_prot i_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rd_valid, .rd_ecc_single, .rd_ecc_double, .rd_block_busy, .cfg_rd_req, .cfg_rd_addr,
    .cfg_rd_valid, .cfg_rd_data, .cfg_done, .cmd_valid, .cmd_kind, .cmd_addr, .cmd_ready,
    .cmd_go, .cmd_refused, .single_fault_flag, .double_fault_flag,
    .protection_violation_flag, .protection_reg);

  ffp_flash_model i_flash (.clk, .resetn, .cfg_rd_req, .cfg_rd_addr, .cfg_rd_valid,
    .cfg_rd_data);

  // ************
  // access tasks
  // ************
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask

  task automatic flt(input logic [2:0] c);
    @(posedge clk);
    rd_valid <= 1'b1;
    {rd_ecc_single, rd_ecc_double, rd_block_busy} <= c;
    @(posedge clk);
    rd_valid <= 1'b0;
    {rd_ecc_single, rd_ecc_double, rd_block_busy} <= 3'h0;
  endtask

  task automatic cmd(input ffp_cmd_t k, input logic [15:0] a, input logic g, input logic v);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind  <= k;
    cmd_addr  <= a;
    #1 chk("cmd_go", {7'h00, cmd_go}, {7'h00, g});
    chk("cmd_refused", {7'h00, cmd_refused}, {7'h00, !g});
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1 chk("violation", {7'h00, protection_violation_flag}, {7'h00, v});
  endtask

  task automatic reset_dut;
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (20) if (cfg_done !== 1'b1) @(posedge clk);
    #1 chk("cfg_done", {7'h00, cfg_done}, 8'h01);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ************
  // tests
  // ************
  initial begin
    reset_dut;
    rd(16'h3028, 8'he0, "prot_load");
    cmd(FFP_CMD_PROGRAM, 16'hff7c, 1'b1, 1'b0);
    cmd(FFP_CMD_BLOCK_ERASE, 16'hc000, 1'b1, 1'b0);
    rd(16'h3030, 8'h00, "unmapped");
    rd(16'h3027, 8'h00, "err_reset");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      if (i == 4) wr(16'h3025, 8'h01);
      flt(ft[i][2:0]);
      rd(16'h3027, {6'h00, ft[i][4:3]}, "err_stat");
      wr(16'h3027, 8'h00);
      rd(16'h3027, {6'h00, ft[i][4:3]}, "err_hold");
      wr(16'h3027, 8'h02);
      rd(16'h3027, {7'h00, ft[i][3]}, "err_clr_double");
      wr(16'h3027, 8'h01);
      rd(16'h3027, 8'h00, "err_clear");
    end
    wr(16'h3025, 8'h00);
    $display("test faults done");
    wr(16'h3028, 8'h88);
    rd(16'h3028, 8'hc8, "prot_grow");
    cmd(FFP_CMD_PROGRAM, 16'hf000, 1'b0, 1'b1);
    cmd(FFP_CMD_PROGRAM, 16'hc000, 1'b0, 1'b1);
    wr(16'h3026, 8'h00);
    rd(16'h3026, 8'h10, "viol_hold");
    wr(16'h3026, 8'h10);
    rd(16'h3026, 8'h00, "viol_clear");
    cmd(FFP_CMD_SECTOR_ERASE, 16'hefff, 1'b1, 1'b0);
    cmd(FFP_CMD_BLOCK_ERASE, 16'hc000, 1'b0, 1'b1);
    wr(16'h3026, 8'h10);
    wr(16'h3028, 8'ha0);
    rd(16'h3028, 8'hc8, "prot_shrink");
    wr(16'h3028, 8'h98);
    rd(16'h3028, 8'hc8, "prot_size_lock");
    wr(16'h3028, 8'h20);
    rd(16'h3028, 8'h68, "prot_pol0");
    cmd(FFP_CMD_PROGRAM, 16'hc000, 1'b0, 1'b1);
    wr(16'h3026, 8'h10);
    wr(16'h3028, 8'h38);
    rd(16'h3028, 8'h78, "prot_size_open");
    cmd(FFP_CMD_PROGRAM, 16'hff7c, 1'b0, 1'b1);
    $display("test protection done");
    @(posedge clk);
    reset_dut;
    rd(16'h3026, 8'h00, "viol_reset");
    rd(16'h3028, 8'he0, "prot_reload");
    wr(16'h3028, 8'h08);
    rd(16'h3028, 8'h48, "prot_hole");
    wr(16'h3028, 8'h88);
    rd(16'h3028, 8'h48, "prot_hole_keep");
    cmd(FFP_CMD_PROGRAM, 16'hf800, 1'b1, 1'b0);
    cmd(FFP_CMD_SECTOR_ERASE, 16'hc000, 1'b0, 1'b1);
    wr(16'h3026, 8'h10);
    cmd(FFP_CMD_BLOCK_ERASE, 16'hf800, 1'b0, 1'b1);
    $display("test reload done");
    end_sim;
  end

  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    end_sim;
  end
endmodule
